// ===== design/tceg_defines.svh
`ifndef TCEG_DEFINES_SVH
`define TCEG_DEFINES_SVH

// Two or four channels
`define TCEG_NUM_CH        4
`define TCEG_VAL_W         16
`define TCEG_STAT_W        8
// Conversion period in ns and derived clock cycles at 20 MHz
`define TCEG_CLK_NS        50
`define TCEG_CONV_NS       1000
`define TCEG_CONV_CYC      ((`TCEG_CONV_NS + `TCEG_CLK_NS - 1) / `TCEG_CLK_NS)
// Restart hold in ns and cycles
`define TCEG_RST_NS        200
`define TCEG_RST_CYC       ((`TCEG_RST_NS + `TCEG_CLK_NS - 1) / `TCEG_CLK_NS)
`define TCEG_CNT_W         8
// Status bit positions
`define TCEG_ST_ERR_BIT    0
`define TCEG_ST_VALID_BIT  7
// Enable default after power-on: all channels in use
`define TCEG_EN_RESET      1'b1

`endif

// ===== design/tceg_pkg.sv
package tceg_pkg;
	typedef enum logic [1:0] {
		TCEG_RUN,
		TCEG_RESTART
	} tceg_mode_t;
endpackage

// ===== design/tceg_chan.sv
`timescale 1ns/10ps
`default_nettype none
`include "tceg_defines.svh"

module tceg_chan (
	// Clock and reset
	input  wire logic                     clock_i,
	input  wire logic                     rst_n_i,
	input  wire logic                     clk_en_i,
	// Control
	input  wire logic                     enable_i,
	input  wire logic                     sample_i,
	input  wire logic                     clear_i,
	// Raw conversion
	input  wire logic [`TCEG_VAL_W-1:0]   raw_i,
	input  wire logic                     fault_i,
	// Results
	output logic      [`TCEG_VAL_W-1:0]   value_o,
	output logic      [`TCEG_STAT_W-1:0]  status_o
);
	typedef struct packed {
		logic [`TCEG_VAL_W-1:0]  val;
		logic [`TCEG_STAT_W-1:0] stat;
	} tceg_ch_state_t;

	tceg_ch_state_t s_q, s_d;

	always_comb begin
		s_d = s_q;
		if (clear_i || !enable_i) begin
			s_d = '0;
		end else if (sample_i) begin
			s_d.val = raw_i;
			s_d.stat = '0;
			s_d.stat[`TCEG_ST_ERR_BIT] = fault_i;
			s_d.stat[`TCEG_ST_VALID_BIT] = 1'b1;
		end
	end

	always_ff @(posedge clock_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			s_q <= '0;
		end else if (clk_en_i) begin
			s_q <= s_d;
		end
	end

	assign value_o  = s_q.val;
	assign status_o = s_q.stat;
endmodule
`default_nettype wire

// ===== design/tceg_top.sv
// Operation
// - Disabled channel skips value arithmetic and error detection; never flags errors.
// - Conversion period stays fixed whatever the enable pattern.
// - After power reset, disabled channel's status and value read zero.
// - Each channel has a boolean enable; all default to enabled.
// - New enable settings apply only at a unit restart.
// - Completed transfer of settings triggers a unit restart.
`timescale 1ns/10ps
`default_nettype none
`include "tceg_defines.svh"

module tceg_top
	import tceg_pkg::*;
#(
	parameter int NUM_CH = `TCEG_NUM_CH
) (
	// Clock and reset
	input  wire logic                            clock_i,
	input  wire logic                            rst_n_i,
	input  wire logic                            clk_en_i,
	// Configuration from software
	input  wire logic [NUM_CH-1:0]               channel_use_setting_i,
	input  wire logic                            xfer_done_i,
	// Converter front end
	input  wire logic [NUM_CH*`TCEG_VAL_W-1:0]   raw_i,
	input  wire logic [NUM_CH-1:0]               fault_i,
	// Results
	output logic      [NUM_CH*`TCEG_VAL_W-1:0]   value_o,
	output logic      [NUM_CH*`TCEG_STAT_W-1:0]  status_o,
	output logic      [NUM_CH-1:0]               active_en_o,
	output logic                                 conv_tick_o,
	output logic                                 restarting_o
);
	localparam logic [`TCEG_CNT_W-1:0] CONV_LAST =
		`TCEG_CNT_W'(`TCEG_CONV_CYC - 1);
	localparam logic [`TCEG_CNT_W-1:0] RST_LAST =
		`TCEG_CNT_W'(`TCEG_RST_CYC - 1);

	initial begin
		if (NUM_CH != 2 && NUM_CH != 4) begin
			$error("channel count must be two or four");
		end
	end

	typedef struct packed {
		tceg_mode_t              mode;
		logic [NUM_CH-1:0]       act_en;
		logic [NUM_CH-1:0]       pend_en;
		logic [`TCEG_CNT_W-1:0]  conv_cnt;
		logic [`TCEG_CNT_W-1:0]  rst_cnt;
		logic                    tick;
		logic                    xfer_s1;
		logic                    xfer_s2;
		logic                    xfer_s3;
	} tceg_state_t;

	tceg_state_t s_q, s_d;
	logic        xfer_rise;

	// Transfer strobe comes from the software side, so it is synchronised
	assign xfer_rise = s_q.xfer_s2 && !s_q.xfer_s3;

	always_comb begin
		s_d = s_q;
		s_d.xfer_s1 = xfer_done_i;
		s_d.xfer_s2 = s_q.xfer_s1;
		s_d.xfer_s3 = s_q.xfer_s2;
		s_d.tick = 1'b0;
		// Written settings are only staged; the active copy is untouched
		s_d.pend_en = channel_use_setting_i;
		unique case (s_q.mode)
			TCEG_RUN: begin
				// Period counter ignores the enables entirely
				if (s_q.conv_cnt == CONV_LAST) begin
					s_d.conv_cnt = '0;
					s_d.tick = 1'b1;
				end else begin
					s_d.conv_cnt = s_q.conv_cnt + 1'b1;
				end
				if (xfer_rise) begin
					s_d.mode = TCEG_RESTART;
					s_d.rst_cnt = '0;
				end
			end
			TCEG_RESTART: begin
				s_d.conv_cnt = '0;
				if (s_q.rst_cnt == RST_LAST) begin
					s_d.mode = TCEG_RUN;
					s_d.act_en = s_q.pend_en;
				end else begin
					s_d.rst_cnt = s_q.rst_cnt + 1'b1;
				end
			end
		endcase
	end

	always_ff @(posedge clock_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			s_q <= '0;
			s_q.mode <= TCEG_RUN;
			s_q.act_en <= {NUM_CH{`TCEG_EN_RESET}};
			s_q.pend_en <= {NUM_CH{`TCEG_EN_RESET}};
		end else if (clk_en_i) begin
			s_q <= s_d;
		end
	end

	assign active_en_o  = s_q.act_en;
	assign conv_tick_o  = s_q.tick;
	assign restarting_o = (s_q.mode == TCEG_RESTART);

	// One gated measurement path per channel
	for (genvar g = 0; g < NUM_CH; g++) begin : g_ch
		tceg_chan u_chan (
			.clock_i  (clock_i),
			.rst_n_i  (rst_n_i),
			.clk_en_i (clk_en_i),
			.enable_i (s_q.act_en[g]),
			.sample_i (s_q.tick),
			.clear_i  (restarting_o),
			.raw_i    (raw_i[g*`TCEG_VAL_W +: `TCEG_VAL_W]),
			.fault_i  (fault_i[g]),
			.value_o  (value_o[g*`TCEG_VAL_W +: `TCEG_VAL_W]),
			.status_o (status_o[g*`TCEG_STAT_W +: `TCEG_STAT_W])
		);

		property p_dis_zero;
			@(posedge clock_i) disable iff (!rst_n_i)
			(!s_q.act_en[g] && clk_en_i) |=> (value_o[g*`TCEG_VAL_W +:
				`TCEG_VAL_W] == '0 && status_o[g*`TCEG_STAT_W +:
				`TCEG_STAT_W] == '0);
		endproperty
		a_dis_zero: assert property (p_dis_zero)
			else $error("disabled channel result not zero");

		property p_no_err;
			@(posedge clock_i) disable iff (!rst_n_i)
			(!s_q.act_en[g] && fault_i[g] && clk_en_i) |=>
				!status_o[g*`TCEG_STAT_W + `TCEG_ST_ERR_BIT];
		endproperty
		a_no_err: assert property (p_no_err)
			else $error("error flagged on disabled channel");

		property p_sample;
			@(posedge clock_i) disable iff (!rst_n_i)
			(s_q.tick && s_q.act_en[g] && !restarting_o && clk_en_i) |=>
				(value_o[g*`TCEG_VAL_W +: `TCEG_VAL_W] ==
				$past(raw_i[g*`TCEG_VAL_W +: `TCEG_VAL_W]));
		endproperty
		a_sample: assert property (p_sample)
			else $error("enabled channel did not capture sample");
	end

	// Helper: cycles since the last tick; all ones marks a fresh start,
	// so the first period after reset or restart counts like any other
	logic [`TCEG_CNT_W-1:0] gap_q;
	always_ff @(posedge clock_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			gap_q <= '1;
		end else if (clk_en_i) begin
			if (restarting_o) begin
				gap_q <= '1;
			end else begin
				gap_q <= s_q.tick ? '0 : gap_q + 1'b1;
			end
		end
	end

	property p_period;
		@(posedge clock_i) disable iff (!rst_n_i)
		(s_q.tick && clk_en_i) |-> (gap_q == CONV_LAST);
	endproperty
	a_period: assert property (p_period)
		else $error("conversion period changed");

	property p_period_max;
		@(posedge clock_i) disable iff (!rst_n_i)
		(gap_q != '1) |-> (gap_q <= CONV_LAST);
	endproperty
	a_period_max: assert property (p_period_max)
		else $error("conversion tick missed");

	property p_restart;
		@(posedge clock_i) disable iff (!rst_n_i)
		(xfer_rise && !restarting_o && clk_en_i) |=> restarting_o;
	endproperty
	a_restart: assert property (p_restart)
		else $error("transfer did not start restart");

	property p_hold_en;
		@(posedge clock_i) disable iff (!rst_n_i)
		(!restarting_o && !$past(restarting_o)) |-> $stable(s_q.act_en);
	endproperty
	a_hold_en: assert property (p_hold_en)
		else $error("enables changed outside restart");

	property p_apply;
		@(posedge clock_i) disable iff (!rst_n_i)
		(restarting_o && s_q.rst_cnt == RST_LAST && clk_en_i) |=>
			(active_en_o == $past(s_q.pend_en) && !restarting_o);
	endproperty
	a_apply: assert property (p_apply)
		else $error("staged enables not applied at restart");

	property p_default;
		@(posedge clock_i)
		$rose(rst_n_i) |-> active_en_o == {NUM_CH{1'b1}};
	endproperty
	a_default: assert property (p_default)
		else $error("enables not all true after reset");

	property p_tick_once;
		@(posedge clock_i) disable iff (!rst_n_i)
		(s_q.tick && clk_en_i) |=> !s_q.tick;
	endproperty
	a_tick_once: assert property (p_tick_once)
		else $error("conversion tick longer than one cycle");

	property p_clear;
		@(posedge clock_i) disable iff (!rst_n_i)
		(restarting_o && clk_en_i) |=>
			(value_o == '0 && status_o == '0);
	endproperty
	a_clear: assert property (p_clear)
		else $error("results not cleared during restart");

	property p_freeze;
		@(posedge clock_i) disable iff (!rst_n_i)
		!clk_en_i |=> ($stable(s_q) && $stable(gap_q));
	endproperty
	a_freeze: assert property (p_freeze)
		else $error("state moved while clock enable low");
endmodule
`default_nettype wire

// ===== test/tceg_top_tb.sv
`timescale 1ns/10ps
`default_nettype none
`include "tceg_defines.svh"

module tceg_top_tb
	import tceg_pkg::*;
;
	localparam int NC  = 4;
	localparam int VW  = `TCEG_VAL_W;
	localparam int SW  = `TCEG_STAT_W;
	localparam int PER = `TCEG_CONV_CYC;
	localparam int RSC = `TCEG_RST_CYC;

	// Stimulus
	logic              clock_i     = 1'b0;
	logic              rst_n_i     = 1'b0;
	logic              clk_en_i    = 1'b1;
	logic              xfer_done_i = 1'b0;
	logic [NC-1:0]     chan_use    = '1;
	logic [NC*VW-1:0]  raw         = 64'h1234_0abc_7fff_0001;
	logic [NC-1:0]     fault       = 4'h2;
	// Observed
	wire logic [NC*VW-1:0] value_o;
	wire logic [NC*SW-1:0] status_o;
	wire logic [NC-1:0]    active_en_o;
	wire logic             conv_tick_o;
	wire logic             restarting_o;
	int                    fails   = 0;
	int                    checked = 0;
	int                    cycles  = 0;
	int                    n;

	tceg_top #(.NUM_CH(NC)) i_dut (
		.clock_i              (clock_i),
		.rst_n_i              (rst_n_i),
		.clk_en_i             (clk_en_i),
		.channel_use_setting_i(chan_use),
		.xfer_done_i          (xfer_done_i),
		.raw_i                (raw),
		.fault_i              (fault),
		.value_o              (value_o),
		.status_o             (status_o),
		.active_en_o          (active_en_o),
		.conv_tick_o          (conv_tick_o),
		.restarting_o         (restarting_o)
	);

	initial begin
		forever #25 clock_i = ~clock_i;
	end

	// Ceiling well above the roughly 185 cycles the sequence needs
	always @(posedge clock_i) begin
		cycles++;
		if (cycles > 3000) begin
			fails++;
			close_out();
		end
	end

	task automatic close_out();
		if (fails == 0 && checked > 0) $display("TEST PASSED");
		else $display("TEST FAILED");
		$finish;
	endtask

	task automatic cmp(string what, logic [63:0] exp, logic [63:0] got);
		checked++;
		if (got !== exp) begin
			$display("mismatch %s expected %h seen %h", what, exp, got);
			fails++;
		end
	endtask

	// Inputs move and outputs are read 1 ns after the rising edge
	task automatic step(int k);
		repeat (k) @(posedge clock_i);
		#1;
	endtask

	task automatic wait_tick(output int k);
		k = 0;
		do begin
			step(1);
			k++;
		end while (conv_tick_o !== 1'b1 && k < 100);
	endtask

	// Disabled channels must read zero value and zero status
	task automatic check_res(logic [NC-1:0] en);
		logic [NC*VW-1:0] ev;
		logic [NC*SW-1:0] es;
		for (int g = 0; g < NC; g++) begin
			ev[g*VW+:VW] = en[g] ? raw[g*VW+:VW] : '0;
			es[g*SW+:SW] = en[g] ? {1'b1, {(SW-2){1'b0}}, fault[g]} : '0;
		end
		cmp("value", 64'(ev), 64'(value_o));
		cmp("status", 64'(es), 64'(status_o));
	endtask

	task automatic restart(logic [NC-1:0] en);
		chan_use = en;
		xfer_done_i = 1'b1;
		n = 0;
		while (restarting_o !== 1'b1 && n < 10) begin
			step(1);
			n++;
		end
		cmp("restarting", 64'h1, 64'(restarting_o));
		xfer_done_i = 1'b0;
		step(1);
		cmp("value in restart", 64'h0, 64'(value_o));
		cmp("status in restart", 64'h0, 64'(status_o));
		n = 1;
		while (restarting_o === 1'b1 && n < 20) begin
			step(1);
			n++;
		end
		cmp("restart length", 64'(RSC), 64'(n));
		cmp("active_en", 64'(en), 64'(active_en_o));
	endtask

	initial begin
		step(4);
		rst_n_i = 1'b1;
		cmp("active_en reset", 64'hf, 64'(active_en_o));
		check_res(4'h0);
		wait_tick(n);
		wait_tick(n);
		cmp("period", 64'(PER), 64'(n));
		step(1);
		check_res(4'hf);
		// Staged change without a transfer must not apply
		chan_use = 4'h5;
		fault = 4'hf;
		wait_tick(n);
		step(1);
		cmp("active_en staged", 64'hf, 64'(active_en_o));
		check_res(4'hf);
		restart(4'h5);
		raw = 64'h0f0f_a5a5_c3c3_9999;
		wait_tick(n);
		wait_tick(n);
		cmp("period gated", 64'(PER), 64'(n));
		step(1);
		check_res(4'h5);
		restart(4'ha);
		fault = 4'h6;
		wait_tick(n);
		step(1);
		check_res(4'ha);
		// Clock enable low must freeze the period counter
		wait_tick(n);
		step(1);
		clk_en_i = 1'b0;
		step(5);
		clk_en_i = 1'b1;
		wait_tick(n);
		cmp("period frozen", 64'(PER - 1), 64'(n));
		close_out();
	end
endmodule
`default_nettype wire
